// ==== rtl/triple_port_fifo.sv ====
// two fifos and two mailboxes behind three ports, with flag logic
// assumes all port clocks and controls are synchronous to clk;
// a port clock rising edge is seen as a low-to-high sample of it
//
// Overview of operation
// - port A data driven only while select and direction are both low
// - port A edge writes fifo1 when selected, write, enabled, no mail, space
// - port A edge reads fifo2 when selected, read, enabled, no mail, avail
// - port A mailbox select: write fills mailbox 1, read empties mailbox 2
// - port B data driven only while its select is low
// - port B edge reads fifo1 when selected, enabled, no mail, avail
// - port B mailbox read takes mailbox 1 and marks it empty
// - port C edge writes fifo2 or, with mailbox select, mailbox 2
// - each port works independently of the other two
// - select and direction matter for accesses only while the port is enabled; the drive enables follow them always
// - fall-through: word loads on the same edge that raises ready
// - fall-through with ready high: advance only on a selected read
// - standard mode: every word, first included, needs a selected read
// - fifo flags resynchronised through two flip-flop stages
// - each fifo flag belongs to the clock of the port that uses it
// - fall-through ready low keeps old word and ignores reads
// - standard empty flag low keeps old word and ignores reads
// - read pointer advances on every output register load from the fifo memory
// - fall-through ready rises on third read edge after first write
// - standard empty flag rises on second read edge after first write
// - read edge in the same cycle as the write does not count
// - mode taken on first write edge after master reset release
// - writes are ignored while the space flag is low
`timescale 1ns/1ps
module triple_port_fifo #(
    parameter int DEPTH = triple_port_fifo_pkg::DEPTH_DEFAULT,
    parameter int AE_OFFSET = triple_port_fifo_pkg::AE_OFFSET_DEFAULT,
    parameter int AF_OFFSET = triple_port_fifo_pkg::AF_OFFSET_DEFAULT
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic port_a_clock,
    input wire logic port_b_clock,
    input wire logic port_c_clock,
    input wire logic fifo1_master_reset_n,
    input wire logic fifo2_master_reset_n,
    input wire logic endian_timing_select,
    input wire triple_port_fifo_pkg::port_a_ctrl_t port_a_ctrl,
    input wire logic [triple_port_fifo_pkg::A_W-1:0] port_a_data_in,
    output logic [triple_port_fifo_pkg::A_W-1:0] port_a_data_out,
    output logic port_a_data_oe,
    input wire triple_port_fifo_pkg::port_b_ctrl_t port_b_ctrl,
    output logic [triple_port_fifo_pkg::B_W-1:0] port_b_data_out,
    output logic port_b_data_oe,
    input wire triple_port_fifo_pkg::port_c_ctrl_t port_c_ctrl,
    input wire logic [triple_port_fifo_pkg::C_W-1:0] port_c_data_in,
    output triple_port_fifo_pkg::flags_t flags,
    output logic [1:0] fall_through_mode
);

    localparam int AW = $clog2(DEPTH);
    localparam int PW = AW + 1;
    localparam int DW = triple_port_fifo_pkg::A_W;
    localparam int NC = triple_port_fifo_pkg::CHANNELS;
    localparam logic [PW-1:0] FULL_LEVEL = PW'(DEPTH);
    localparam logic [PW-1:0] AF_LEVEL = PW'(DEPTH - AF_OFFSET);
    localparam logic [PW-1:0] AE_LEVEL = PW'(AE_OFFSET);
    localparam logic [PW-1:0] PTR_ONE = PW'(1);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0 ||
        AE_OFFSET < 1 || AE_OFFSET >= DEPTH ||
        AF_OFFSET < 1 || AF_OFFSET >= DEPTH) begin : bad_params
        $error("depth must be a power of two and offsets inside it");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DEPTH-1:0][DW-1:0] mem;
        logic [PW-1:0] wptr;
        logic [PW-1:0] rptr;
        logic [DW-1:0] outreg;
        logic mode;
        logic mode_done;
        logic ready;
    } chan_t;

    typedef struct packed {
        chan_t [NC-1:0] ch;
        logic [DW-1:0] mail1;
        logic [DW-1:0] mail2;
        logic mail1_full_n;
        logic mail2_full_n;
        logic [2:0] clk_prev;
    } state_t;

    state_t s;
    state_t next_s;

    // ------------------------------------------------------------
    // port clock edges
    // ------------------------------------------------------------
    logic [2:0] clk_now;
    logic [2:0] rise;
    logic [NC-1:0] wedge;
    logic [NC-1:0] redge;
    logic [NC-1:0] master_n;

    assign clk_now = {port_c_clock, port_b_clock, port_a_clock};
    assign rise = clk_now & ~s.clk_prev;
    assign wedge = {rise[2], rise[0]};
    assign redge = {rise[0], rise[1]};
    assign master_n = {fifo2_master_reset_n, fifo1_master_reset_n};

    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------
    // select and direction only qualify the enable, so they may move
    // freely while the port is disabled
    logic a_sel;
    logic a_fifo_wr;
    logic a_mail_wr;
    logic a_fifo_rd;
    logic a_mail_rd;
    logic b_fifo_rd;
    logic b_mail_rd;
    logic c_fifo_wr;
    logic c_mail_wr;

    assign a_sel = port_a_ctrl.access_enable & ~port_a_ctrl.select_n;
    assign a_fifo_wr = a_sel & port_a_ctrl.direction &
                       ~port_a_ctrl.mailbox_select;
    assign a_mail_wr = a_sel & port_a_ctrl.direction &
                       port_a_ctrl.mailbox_select;
    assign a_fifo_rd = a_sel & ~port_a_ctrl.direction &
                       ~port_a_ctrl.mailbox_select;
    assign a_mail_rd = a_sel & ~port_a_ctrl.direction &
                       port_a_ctrl.mailbox_select;
    assign b_fifo_rd = port_b_ctrl.read_enable & ~port_b_ctrl.select_n &
                       ~port_b_ctrl.mailbox_select;
    assign b_mail_rd = port_b_ctrl.read_enable & ~port_b_ctrl.select_n &
                       port_b_ctrl.mailbox_select;
    assign c_fifo_wr = port_c_ctrl.write_enable &
                       ~port_c_ctrl.mailbox_select;
    assign c_mail_wr = port_c_ctrl.write_enable &
                       port_c_ctrl.mailbox_select;

    logic [NC-1:0] we;
    logic [NC-1:0] re;
    logic [NC-1:0][DW-1:0] wdata;

    assign we = {c_fifo_wr, a_fifo_wr};
    assign re = {a_fifo_rd, b_fifo_rd};
    assign wdata[0] = port_a_data_in;
    assign wdata[1] = {{(DW - triple_port_fifo_pkg::C_W){1'b0}},
                       port_c_data_in};

    // ------------------------------------------------------------
    // per-channel synchronisers and flags
    // ------------------------------------------------------------
    // both pointers cross to the far side through two stages stepped by
    // the far port's clock, so flags lag by two far-side edges
    logic [NC-1:0][PW-1:0] wsync;
    logic [NC-1:0][PW-1:0] rsync;
    logic [NC-1:0][PW-1:0] fill_w;
    logic [NC-1:0][PW-1:0] words_r;
    logic [NC-1:0] space;
    logic [NC-1:0] avail;
    logic [NC-1:0] ae_n;
    logic [NC-1:0] af_n;

    for (genvar c = 0; c < NC; c++) begin : chan
        ptr_sync #(
            .W(PW)
        ) u_wsync (
            .clk(clk),
            .reset_n(reset_n),
            .clear(~master_n[c]),
            .step(redge[c]),
            .d(s.ch[c].wptr),
            .q(wsync[c])
        );

        ptr_sync #(
            .W(PW)
        ) u_rsync (
            .clk(clk),
            .reset_n(reset_n),
            .clear(~master_n[c]),
            .step(wedge[c]),
            .d(s.ch[c].rptr),
            .q(rsync[c])
        );

        // write-side view: changes only on this channel's write edges
        assign fill_w[c] = s.ch[c].wptr - rsync[c];
        assign space[c] = s.ch[c].mode_done &
                          (fill_w[c] != FULL_LEVEL);
        assign af_n[c] = fill_w[c] < AF_LEVEL;

        // read-side view: changes only on this channel's read edges;
        // a word in the output register is not counted
        assign words_r[c] = wsync[c] - s.ch[c].rptr;
        assign ae_n[c] = words_r[c] > AE_LEVEL;
        assign avail[c] = (s.ch[c].mode == triple_port_fifo_pkg::MODE_STANDARD)
                          ? (words_r[c] != '0) : s.ch[c].ready;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.clk_prev = clk_now;
        for (int c = 0; c < NC; c++) begin
            if (!master_n[c]) begin
                next_s.ch[c].wptr = '0;
                next_s.ch[c].rptr = '0;
                next_s.ch[c].outreg = '0;
                next_s.ch[c].ready = 1'b0;
                next_s.ch[c].mode_done = 1'b0;
            end else begin
                // write side
                if (wedge[c] && !s.ch[c].mode_done) begin
                    next_s.ch[c].mode = endian_timing_select;
                    next_s.ch[c].mode_done = 1'b1;
                end
                if (wedge[c] && we[c] && space[c]) begin
                    next_s.ch[c].mem[s.ch[c].wptr[AW-1:0]] = wdata[c];
                    next_s.ch[c].wptr = s.ch[c].wptr + PTR_ONE;
                end
                // read side; a write in this very cycle is not yet in
                // wsync, so this edge cannot count for it
                if (redge[c]) begin
                    if (s.ch[c].mode == triple_port_fifo_pkg::MODE_STANDARD)
                    begin
                        if (re[c] && avail[c]) begin
                            next_s.ch[c].outreg =
                                s.ch[c].mem[s.ch[c].rptr[AW-1:0]];
                            next_s.ch[c].rptr =
                                s.ch[c].rptr + PTR_ONE;
                        end
                    end else if (!s.ch[c].ready || re[c]) begin
                        // ready low: reads are moot, a waiting word loads
                        // on the edge that raises ready
                        if (words_r[c] != '0) begin
                            next_s.ch[c].outreg =
                                s.ch[c].mem[s.ch[c].rptr[AW-1:0]];
                            next_s.ch[c].rptr =
                                s.ch[c].rptr + PTR_ONE;
                            next_s.ch[c].ready = 1'b1;
                        end else begin
                            next_s.ch[c].ready = 1'b0;
                        end
                    end
                end
            end
        end

        // mailbox 1: written from port A, read on port B; a read and a
        // write in one cycle on a full mailbox leave it empty, so the new mail is lost
        if (!fifo1_master_reset_n) begin
            next_s.mail1_full_n = 1'b1;
        end else begin
            if (rise[1] && b_mail_rd) begin
                next_s.ch[0].outreg = s.mail1;
                next_s.mail1_full_n = 1'b1;
            end
            if (rise[0] && a_mail_wr && s.mail1_full_n) begin
                next_s.mail1 = port_a_data_in;
                next_s.mail1_full_n = 1'b0;
            end
        end

        // mailbox 2: written from port C, read on port A
        if (!fifo2_master_reset_n) begin
            next_s.mail2_full_n = 1'b1;
        end else begin
            if (rise[0] && a_mail_rd) begin
                next_s.ch[1].outreg = s.mail2;
                next_s.mail2_full_n = 1'b1;
            end
            if (rise[2] && c_mail_wr && s.mail2_full_n) begin
                next_s.mail2 = wdata[1];
                next_s.mail2_full_n = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
            s.mail1_full_n <= 1'b1;
            s.mail2_full_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // drive enables follow the pins directly, independent of the clock
    assign port_a_data_oe = ~port_a_ctrl.select_n &
                            ~port_a_ctrl.direction;
    assign port_b_data_oe = ~port_b_ctrl.select_n;
    assign port_a_data_out = s.ch[1].outreg;
    // only the low half-word of each fifo1 word reaches port B
    assign port_b_data_out = s.ch[0].outreg[triple_port_fifo_pkg::B_W-1:0];

    assign flags.fifo1_space_flag = space[0];
    assign flags.fifo1_almost_full_n = af_n[0];
    assign flags.fifo1_avail_flag_portb = avail[0];
    assign flags.fifo1_almost_empty_n = ae_n[0];
    assign flags.fifo2_space_flag = space[1];
    assign flags.fifo2_almost_full_n = af_n[1];
    assign flags.fifo2_avail_flag_porta = avail[1];
    assign flags.fifo2_almost_empty_n = ae_n[1];
    assign flags.mailbox1_full_n = s.mail1_full_n;
    assign flags.mailbox2_full_n = s.mail2_full_n;

    assign fall_through_mode[0] = s.ch[0].mode_done &
        (s.ch[0].mode == triple_port_fifo_pkg::MODE_FALL_THROUGH);
    assign fall_through_mode[1] = s.ch[1].mode_done &
        (s.ch[1].mode == triple_port_fifo_pkg::MODE_FALL_THROUGH);

endmodule : triple_port_fifo

// ==== rtl/triple_port_fifo_pkg.sv ====
// constants and port bundles shared by the triple-port buffer
// assumes one system clock samples all three port clocks as plain inputs
package triple_port_fifo_pkg;

    // ------------------------------------------------------------
    // widths and sizes
    // ------------------------------------------------------------
    localparam int A_W = 36;
    localparam int B_W = 18;
    localparam int C_W = 18;
    localparam int DEPTH_DEFAULT = 256;
    localparam int AE_OFFSET_DEFAULT = 8;
    localparam int AF_OFFSET_DEFAULT = 8;
    localparam int CHANNELS = 2;

    // ------------------------------------------------------------
    // channel indices and timing-mode encoding
    // ------------------------------------------------------------
    localparam int FIFO1 = 0;
    localparam int FIFO2 = 1;
    localparam logic MODE_STANDARD = 1'b1;
    localparam logic MODE_FALL_THROUGH = 1'b0;

    // ------------------------------------------------------------
    // port bundles
    // ------------------------------------------------------------
    typedef struct packed {
        logic select_n;
        logic direction;
        logic access_enable;
        logic mailbox_select;
    } port_a_ctrl_t;

    typedef struct packed {
        logic select_n;
        logic read_enable;
        logic mailbox_select;
    } port_b_ctrl_t;

    typedef struct packed {
        logic write_enable;
        logic mailbox_select;
    } port_c_ctrl_t;

    typedef struct packed {
        logic fifo1_space_flag;
        logic fifo1_almost_full_n;
        logic fifo1_avail_flag_portb;
        logic fifo1_almost_empty_n;
        logic fifo2_space_flag;
        logic fifo2_almost_full_n;
        logic fifo2_avail_flag_porta;
        logic fifo2_almost_empty_n;
        logic mailbox1_full_n;
        logic mailbox2_full_n;
    } flags_t;

endpackage : triple_port_fifo_pkg

// ==== rtl/ptr_sync.sv ====
// two-stage pointer resynchroniser stepped by a port clock rising edge
// assumes step is a one-cycle pulse of the system clock
`timescale 1ns/1ps
module ptr_sync #(
    parameter int W = 9
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic step,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } sync_state_t;

    sync_state_t s;
    sync_state_t next_s;

    // ------------------------------------------------------------
    // stages
    // ------------------------------------------------------------
    // stage1 feeds stage2 only; nothing else looks at it
    always_comb begin
        next_s = s;
        if (clear) begin
            next_s = '0;
        end else if (step) begin
            next_s.stage1 = d;
            next_s.stage2 = s.stage1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q = s.stage2;

endmodule : ptr_sync

// ==== sim/port_agent.sv ====
// far-side masters: one port clock pulse per request
// assumes go is driven at the falling edge of clk
`timescale 1ns/1ps
module port_agent (
    input wire logic clk,
    input wire logic [2:0] go,
    output logic [2:0] port_clk
);
    // ----
    // port clocks
    // ----
    // clocks stand low between requests
    initial port_clk = 3'h0;
    always @(negedge clk) begin
        port_clk <= go;
    end
endmodule : port_agent

// ==== sim/triple_port_fifo_props.sv ====
// port-level assertions for the triple-port buffer
// assumes port clocks are sampled as data on clk
`timescale 1ns/1ps
module triple_port_fifo_props (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic port_a_clock,
    input wire logic port_b_clock,
    input wire logic port_c_clock,
    input wire logic fifo1_master_reset_n,
    input wire logic fifo2_master_reset_n,
    input wire triple_port_fifo_pkg::port_a_ctrl_t port_a_ctrl,
    input wire logic port_a_data_oe,
    input wire triple_port_fifo_pkg::port_b_ctrl_t port_b_ctrl,
    input wire logic [triple_port_fifo_pkg::B_W-1:0] port_b_data_out,
    input wire logic port_b_data_oe,
    input wire triple_port_fifo_pkg::port_c_ctrl_t port_c_ctrl,
    input wire triple_port_fifo_pkg::flags_t flags
);
    // ----
    // edge and reset helpers
    // ----
    logic [4:0] prev;
    logic a_edge, b_edge, c_edge, ok1, ok2, a_mail_wr, b_mail_rd;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prev <= 5'h0;
        end else begin
            prev <= {fifo2_master_reset_n, fifo1_master_reset_n,
                port_c_clock, port_b_clock, port_a_clock};
        end
    end
    assign a_edge = port_a_clock & ~prev[0];
    assign b_edge = port_b_clock & ~prev[1];
    assign c_edge = port_c_clock & ~prev[2];
    // master resets move flags with no port edge
    assign ok1 = fifo1_master_reset_n & prev[3];
    assign ok2 = fifo2_master_reset_n & prev[4];
    assign a_mail_wr = a_edge & ~port_a_ctrl.select_n & port_a_ctrl.direction
        & port_a_ctrl.access_enable & port_a_ctrl.mailbox_select;
    assign b_mail_rd = b_edge & ~port_b_ctrl.select_n
        & port_b_ctrl.read_enable & port_b_ctrl.mailbox_select;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    chk_a_drive: assert property (
        port_a_data_oe == (!port_a_ctrl.select_n && !port_a_ctrl.direction))
        else $error("A drive wrong");
    chk_b_drive: assert property (
        port_b_data_oe == !port_b_ctrl.select_n)
        else $error("B drive wrong");
    chk_space1_edge: assert property (
        ok1 && !$stable(flags.fifo1_space_flag) |-> $past(a_edge)
        || $past(a_edge, 2)) else $error("space1 moved");
    chk_avail1_edge: assert property (
        ok1 && !$stable(flags.fifo1_avail_flag_portb) |-> $past(b_edge)
        || $past(b_edge, 2)) else $error("avail1 moved");
    chk_space2_edge: assert property (
        ok2 && !$stable(flags.fifo2_space_flag) |-> $past(c_edge)
        || $past(c_edge, 2)) else $error("space2 moved");
    chk_avail2_edge: assert property (
        ok2 && !$stable(flags.fifo2_avail_flag_porta) |-> $past(a_edge)
        || $past(a_edge, 2)) else $error("avail2 moved");
    chk_mail1_set: assert property (
        a_mail_wr && ok1 |-> ##[1:2] !flags.mailbox1_full_n)
        else $error("mail1 not set");
    chk_mail1_clear: assert property (
        b_mail_rd && !a_mail_wr && ok1 && !flags.mailbox1_full_n
        |-> ##[1:2] flags.mailbox1_full_n)
        else $error("mail1 kept");
    chk_mail2_set: assert property (
        c_edge && port_c_ctrl.write_enable && port_c_ctrl.mailbox_select
        && ok2 |-> ##[1:2] !flags.mailbox2_full_n)
        else $error("mail2 not set");
    chk_b_hold: assert property (
        ok1 && !$stable(port_b_data_out) |-> $past(b_edge) || $past(b_edge, 2))
        else $error("B data moved");
    cov_fifo1_full: cover property (ok1 && a_edge && !flags.fifo1_space_flag);
    cov_mail1_read: cover property (b_mail_rd);
    cov_ready2_rise: cover property ($rose(flags.fifo2_avail_flag_porta));
endmodule : triple_port_fifo_props

bind triple_port_fifo triple_port_fifo_props u_props (
    .clk(clk), .reset_n(reset_n), .port_a_clock(port_a_clock),
    .port_b_clock(port_b_clock), .port_c_clock(port_c_clock),
    .fifo1_master_reset_n(fifo1_master_reset_n),
    .fifo2_master_reset_n(fifo2_master_reset_n),
    .port_a_ctrl(port_a_ctrl), .port_a_data_oe(port_a_data_oe),
    .port_b_ctrl(port_b_ctrl), .port_b_data_out(port_b_data_out),
    .port_b_data_oe(port_b_data_oe), .port_c_ctrl(port_c_ctrl),
    .flags(flags)
);

// ==== sim/testbench.sv ====
// self-checking bench for the triple-port buffer
// assumes port clocks come from port_agent, one pulse per access
`timescale 1ns/1ps
module testbench;
    logic clk, reset_n, mr1_n, mr2_n, ets, a_oe, b_oe;
    logic [2:0] go, pclk;
    logic [1:0] ftm;
    logic [35:0] a_drv, a_out, a_wire, d, e, b36;
    logic [17:0] b_out, c_in;
    triple_port_fifo_pkg::port_a_ctrl_t a_ctrl;
    triple_port_fifo_pkg::port_b_ctrl_t b_ctrl;
    triple_port_fifo_pkg::port_c_ctrl_t c_ctrl;
    triple_port_fifo_pkg::flags_t flags;
    logic [35:0] q1[$], q2[$];
    int error_cnt, samples_checked, seed, i;
    // shared A lines
    assign a_wire = a_oe ? a_out : a_drv;
    assign b36 = {18'h0, b_out};
    triple_port_fifo u_triple_port_fifo (
        .clk(clk), .reset_n(reset_n), .port_a_clock(pclk[0]),
        .port_b_clock(pclk[1]), .port_c_clock(pclk[2]),
        .fifo1_master_reset_n(mr1_n), .fifo2_master_reset_n(mr2_n),
        .endian_timing_select(ets), .port_a_ctrl(a_ctrl),
        .port_a_data_in(a_wire), .port_a_data_out(a_out),
        .port_a_data_oe(a_oe), .port_b_ctrl(b_ctrl),
        .port_b_data_out(b_out), .port_b_data_oe(b_oe),
        .port_c_ctrl(c_ctrl), .port_c_data_in(c_in), .flags(flags),
        .fall_through_mode(ftm));
    port_agent u_port_agent (.clk(clk), .go(go), .port_clk(pclk));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ----
    // compare and access tasks
    // ----
    task automatic check_flag(string n, logic ex, logic got);
        check_data(n, {35'h0, ex}, {35'h0, got});
    endtask : check_flag
    task automatic check_data(string n, logic [35:0] ex, logic [35:0] got);
        samples_checked++;
        if (got !== ex) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", n, ex, got);
        end
    endtask : check_data
    task automatic stop_test;
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test
    // enables stand around the pulse, then drop
    task automatic port_edge(logic [2:0] m);
        @(negedge clk) go <= m;
        @(negedge clk) go <= 3'h0;
        @(negedge clk) a_ctrl.access_enable = 1'b0;
        b_ctrl.read_enable = 1'b0;
        c_ctrl.write_enable = 1'b0;
        @(negedge clk);
    endtask : port_edge
    task automatic a_acc(logic dir, logic mb, logic [35:0] v);
        a_ctrl = '{1'b0, dir, 1'b1, mb};
        a_drv = v;
        port_edge(3'h1);
    endtask : a_acc
    task automatic b_read(logic mb);
        b_ctrl = '{1'b0, 1'b1, mb};
        port_edge(3'h2);
    endtask : b_read
    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        stop_test();
    end
    // ----
    // main sequence
    // ----
    initial begin
        seed = 32'hdbd2ca38;
        error_cnt = 0;
        samples_checked = 0;
        reset_n = 1'b0;
        mr1_n = 1'b0;
        mr2_n = 1'b0;
        ets = triple_port_fifo_pkg::MODE_STANDARD;
        go = 3'h0;
        a_drv = 36'h0;
        c_in = 18'h0;
        a_ctrl = 4'hc;
        b_ctrl = 3'h4;
        c_ctrl = 2'h0;
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        check_flag("space1", 1'b0, flags.fifo1_space_flag);
        @(negedge clk);
        mr1_n = 1'b1;
        mr2_n = 1'b1;
        port_edge(3'h5);
        check_flag("space1", 1'b1, flags.fifo1_space_flag);
        check_flag("space2", 1'b1, flags.fifo2_space_flag);
        check_flag("mode", 1'b0, ftm[0]);
        for (i = 0; i < 4; i++) begin
            a_ctrl = '{i[0], i[1], 1'b0, 1'b1};
            b_ctrl = '{i[0], 1'b0, 1'b1};
            port_edge(3'h3);
            check_flag("a_oe", i == 0, a_oe);
            check_flag("b_oe", !i[0], b_oe);
            check_flag("mailbox1_full_n", 1'b1, flags.mailbox1_full_n);
        end
        for (i = 0; i < 257; i++) begin
            d = 36'({$random(seed), $random(seed)});
            if (q1.size() < triple_port_fifo_pkg::DEPTH_DEFAULT) begin
                q1.push_back(d);
            end
            a_acc(1'b1, 1'b0, d);
        end
        check_flag("space1", 1'b0, flags.fifo1_space_flag);
        check_flag("afull1", 1'b0, flags.fifo1_almost_full_n);
        b_ctrl = '{1'b0, 1'b0, 1'b0};
        port_edge(3'h2);
        check_flag("avail1", 1'b0, flags.fifo1_avail_flag_portb);
        port_edge(3'h2);
        check_flag("avail1", 1'b1, flags.fifo1_avail_flag_portb);
        check_flag("aempty1", 1'b1, flags.fifo1_almost_empty_n);
        check_data("b_out", 36'h0, b36);
        while (q1.size() > 0) begin
            d = q1.pop_front();
            b_read(1'b0);
            check_data("b_out", 36'(d[17:0]), b36);
        end
        check_flag("avail1", 1'b0, flags.fifo1_avail_flag_portb);
        b_read(1'b0);
        check_data("b_out", 36'(d[17:0]), b36);
        port_edge(3'h1);
        check_flag("space1", 1'b0, flags.fifo1_space_flag);
        port_edge(3'h1);
        check_flag("space1", 1'b1, flags.fifo1_space_flag);
        d = 36'({$random(seed), $random(seed)});
        a_acc(1'b1, 1'b1, d);
        check_flag("mailbox1_full_n", 1'b0, flags.mailbox1_full_n);
        b_read(1'b1);
        check_data("b_out", 36'(d[17:0]), b36);
        check_flag("mailbox1_full_n", 1'b1, flags.mailbox1_full_n);
        for (i = 0; i < 3; i++) begin
            d = 36'({$random(seed), $random(seed)});
            q1.push_back(d);
            q2.push_back({18'h0, d[35:18]});
            a_ctrl = '{1'b0, 1'b1, 1'b1, 1'b0};
            a_drv = d;
            c_ctrl = '{1'b1, 1'b0};
            c_in = d[35:18];
            port_edge(3'h5);
        end
        e = 36'($random(seed));
        c_ctrl = '{1'b1, 1'b1};
        c_in = e[17:0];
        port_edge(3'h4);
        check_flag("mailbox2_full_n", 1'b0, flags.mailbox2_full_n);
        a_ctrl = '{1'b0, 1'b0, 1'b0, 1'b0};
        b_ctrl = '{1'b0, 1'b0, 1'b0};
        port_edge(3'h3);
        port_edge(3'h3);
        check_flag("avail2", 1'b1, flags.fifo2_avail_flag_porta);
        a_acc(1'b0, 1'b1, 36'h0);
        check_data("a_out", {18'h0, e[17:0]}, a_out);
        check_flag("mailbox2_full_n", 1'b1, flags.mailbox2_full_n);
        for (i = 0; i < 3; i++) begin
            d = q1.pop_front();
            e = q2.pop_front();
            a_ctrl = '{1'b0, 1'b0, 1'b1, 1'b0};
            b_ctrl = '{1'b0, 1'b1, 1'b0};
            port_edge(3'h3);
            check_data("a_out", e, a_out);
            check_data("b_out", 36'(d[17:0]), b36);
        end
        mr2_n = 1'b0;
        ets = triple_port_fifo_pkg::MODE_FALL_THROUGH;
        @(negedge clk);
        mr2_n = 1'b1;
        port_edge(3'h4);
        check_flag("mode", 1'b1, ftm[1]);
        for (i = 0; i < 2; i++) begin
            d = 36'($random(seed));
            q2.push_back({18'h0, d[17:0]});
            c_ctrl = '{1'b1, 1'b0};
            c_in = d[17:0];
            port_edge(3'h4);
        end
        for (i = 1; i <= 4; i++) begin
            port_edge(3'h1);
            check_flag("ready2", i >= 3, flags.fifo2_avail_flag_porta);
        end
        check_data("a_out", q2.pop_front(), a_out);
        check_flag("aempty2", 1'b0, flags.fifo2_almost_empty_n);
        a_acc(1'b0, 1'b0, 36'h0);
        e = q2.pop_front();
        check_data("a_out", e, a_out);
        a_acc(1'b0, 1'b0, 36'h0);
        check_flag("ready2", 1'b0, flags.fifo2_avail_flag_porta);
        check_data("a_out", e, a_out);
        stop_test();
    end
endmodule : testbench
